/* inc/lasm_pkg.sv */
// Package for the limit alarm status and mask block.
// Assumes a single 25 MHz core clock and an 8-bit register port fed by the serial bus engine.
package lasm_pkg;

    localparam int unsigned NUM_FLAGS  = 8;
    localparam int unsigned ADDR_WIDTH = 8;

    // Register offsets on the internal register port.
    localparam logic [7:0] ADDR_LIMIT_ERROR_FLAGS = 8'h01;
    localparam logic [7:0] ADDR_ALARM_MASK_BITS   = 8'h03;

    // Reset values.
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [7:0] READ_IDLE    = 8'h00;

    // Flag position of the temperature channel in modes 0, 2 and 3.
    localparam logic [2:0] TEMP_BIT = 3'h7;

    // Input-configuration modes.
    localparam logic [1:0] MODE_SINGLE_TEMP = 2'h0;
    localparam logic [1:0] MODE_SINGLE_ALL  = 2'h1;
    localparam logic [1:0] MODE_PSEUDO_DIFF = 2'h2;
    localparam logic [1:0] MODE_MIXED       = 2'h3;

    // Implemented flag bits per mode; zeros are reserved and read as zero.
    localparam logic [7:0] VALID_MODE0 = 8'hFF;
    localparam logic [7:0] VALID_MODE1 = 8'hFF;
    localparam logic [7:0] VALID_MODE2 = 8'h8F;
    localparam logic [7:0] VALID_MODE3 = 8'hBF;

    // Layout of the flag and mask bits for a given mode.
    function automatic logic [7:0] lasm_valid_bits(input logic [1:0] mode);
        logic [7:0] bits;
        bits = VALID_MODE0;
        case (mode)
            MODE_SINGLE_TEMP: bits = VALID_MODE0;
            MODE_SINGLE_ALL:  bits = VALID_MODE1;
            MODE_PSEUDO_DIFF: bits = VALID_MODE2;
            MODE_MIXED:       bits = VALID_MODE3;
            default:          bits = VALID_MODE0;
        endcase
        return bits;
    endfunction

endpackage

/* inc/lasm_bank_if.sv */
// Carrier between the alarm control logic and the flag and mask bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface lasm_bank_if;
    logic [7:0] setVec;
    logic       statusClr;
    logic       maskWr;
    logic [7:0] maskWrData;
    logic [7:0] validBits;
    logic [7:0] statusQ;
    logic [7:0] maskQ;

    modport ctrl (output setVec, output statusClr, output maskWr, output maskWrData, output validBits,
                  input statusQ, input maskQ);
    modport bank (input setVec, input statusClr, input maskWr, input maskWrData, input validBits,
                  output statusQ, output maskQ);
endinterface

/* design/lasm_flag_bank.sv */
// Storage of the limit error flags and the alarm mask bits.
// Assumes set vectors and write strobes come from logic on the same clock.
`timescale 1ns/1ns
module lasm_flag_bank
    import lasm_pkg::*;
(
    // Clock, reset and enable
    input  wire logic     core_clk,
    input  wire logic     reset_n,
    input  wire logic     ce,
    // Control side
    lasm_bank_if.bank     bankPort
);

    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;

    // A set arriving with the clear survives, so no event is lost.
    assign status_next = (bankPort.statusClr ? STATUS_RESET : status_reg) | bankPort.setVec;
    // Reserved positions of the current mode are never written into the mask.
    assign mask_next   = bankPort.maskWr ? (bankPort.maskWrData & bankPort.validBits) : mask_reg;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status_reg <= STATUS_RESET;
            mask_reg   <= MASK_RESET;
        end else if (ce) begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
        end
    end

    assign bankPort.statusQ = status_reg;
    assign bankPort.maskQ   = mask_reg;

endmodule // lasm_flag_bank

/* design/lasm_alarm_top.sv */
// Limit alarm status and mask logic: maps comparator events to flags and drives the alarm pin.
// Assumes the serial bus engine, sequencer and configuration registers sit on the same clock.
`timescale 1ns/1ns
module lasm_alarm_top
    import lasm_pkg::*;
(
    // Clock, reset and enable
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    input  wire logic                  ce,
    // Register port from the serial bus engine
    input  wire logic                  hostWrEn,
    input  wire logic                  hostRdEn,
    input  wire logic [ADDR_WIDTH-1:0] hostAddr,
    input  wire logic [7:0]            hostWrData,
    output logic [7:0]                 hostRdData,
    // Configuration fields held elsewhere
    input  wire logic [1:0]            inputMode,
    input  wire logic                  alarmPinEnable,
    input  wire logic                  alarmClear,
    input  wire logic [7:0]            chanDisable,
    input  wire logic                  statusClr,
    // Window comparator results from the sequencer
    input  wire logic                  evtValid,
    input  wire logic [2:0]            evtChannel,
    input  wire logic                  evtAboveHigh,
    input  wire logic                  evtBelowLow,
    // Pin and sequencer control
    output logic                       alarmOut_n,
    output logic                       monitorHalt
);

    lasm_bank_if bankBus ();

    logic [7:0] validW;
    logic       isTempW;
    logic       limitHitW;
    logic       chanAllowedW;
    logic [7:0] setVecW;
    logic [7:0] pendingW;
    logic       alarmAssertW;
    logic       selStatusW;
    logic       selMaskW;
    logic [7:0] readMuxW;

    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic       alarmOut_n_reg;
    logic       alarmOut_n_next;
    logic       monitorHalt_reg;
    logic       monitorHalt_next;

    // The configured mode picks which flag positions exist.
    assign validW = lasm_valid_bits(inputMode);

    // Temperature has only an upper limit; voltage inputs trip on either side.
    assign isTempW   = (inputMode != MODE_SINGLE_ALL) && (evtChannel == TEMP_BIT);
    assign limitHitW = isTempW ? evtAboveHigh : (evtAboveHigh | evtBelowLow);

    // Disabled channels and reserved positions can never raise a flag.
    assign chanAllowedW = !chanDisable[evtChannel] && validW[evtChannel];
    assign setVecW      = (evtValid && limitHitW && chanAllowedW) ? (8'h01 << evtChannel) : STATUS_RESET;

    // Host writes to the flag register land nowhere; only the mask accepts data.
    assign selStatusW = (hostAddr == ADDR_LIMIT_ERROR_FLAGS);
    assign selMaskW   = (hostAddr == ADDR_ALARM_MASK_BITS);

    assign bankBus.setVec     = setVecW;
    assign bankBus.statusClr  = statusClr;
    assign bankBus.maskWr     = hostWrEn && selMaskW;
    assign bankBus.maskWrData = hostWrData;
    assign bankBus.validBits  = validW;

    lasm_flag_bank u_bank (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .bankPort (bankBus.bank)
    );

    // Masked flags still sit in the flag register; they just stop reaching the pin.
    assign pendingW        = bankBus.statusQ & ~bankBus.maskQ & validW;
    assign alarmAssertW    = (|pendingW) && alarmPinEnable && !alarmClear;
    assign alarmOut_n_next = !alarmAssertW;
    assign monitorHalt_next = alarmClear;

    // Reserved bits of the current layout read as zero; unmapped offsets return zero.
    assign readMuxW    = selStatusW ? (bankBus.statusQ & validW) :
                         selMaskW   ? (bankBus.maskQ & validW) : READ_IDLE;
    assign rdData_next = hostRdEn ? readMuxW : rdData_reg;

    // A low clock enable freezes every register here, so events arriving then are dropped, not queued.

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdData_reg      <= READ_IDLE;
            alarmOut_n_reg  <= 1'b1;
            monitorHalt_reg <= 1'b0;
        end else if (ce) begin
            rdData_reg      <= rdData_next;
            alarmOut_n_reg  <= alarmOut_n_next;
            monitorHalt_reg <= monitorHalt_next;
        end
    end

    assign hostRdData  = rdData_reg;
    assign alarmOut_n  = alarmOut_n_reg;
    assign monitorHalt = monitorHalt_reg;

    // The pin can only move one edge after the flag register, so a read and the pin may disagree
    // for one cycle; this keeps the pin glitch free at the cost of that latency.

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_flag_set_event: assert property (
        (ce && (setVecW != STATUS_RESET)) |=> ((bankBus.statusQ & $past(setVecW)) == $past(setVecW)))
        else $error("Flag not set after limit event.");

    a_status_write_ignored: assert property (
        (ce && hostWrEn && selStatusW && !statusClr && (setVecW == STATUS_RESET))
        |=> (bankBus.statusQ == $past(bankBus.statusQ)))
        else $error("Host write changed the flag register.");

    a_temp_high_only: assert property (
        (ce && evtValid && (inputMode != MODE_SINGLE_ALL) && (evtChannel == TEMP_BIT)
         && !evtAboveHigh && evtBelowLow && !bankBus.statusQ[TEMP_BIT] && !chanDisable[TEMP_BIT])
        |=> !bankBus.statusQ[TEMP_BIT])
        else $error("Temperature flag set by a low-limit event.");

    a_mode2_reserved: assert property (
        (inputMode == MODE_PSEUDO_DIFF) |-> ((setVecW & ~VALID_MODE2) == STATUS_RESET))
        else $error("Reserved flag raised in mode 2.");

    a_mode3_reserved: assert property (
        (inputMode == MODE_MIXED) |-> ((setVecW & ~VALID_MODE3) == STATUS_RESET))
        else $error("Reserved flag raised in mode 3.");

    a_mask_blocks_pin: assert property (
        (ce && (pendingW == STATUS_RESET)) |=> alarmOut_n)
        else $error("Alarm pin driven with every flag masked.");

    a_mask_write_back: assert property (
        (ce && hostWrEn && selMaskW) |=> (bankBus.maskQ == ($past(hostWrData) & $past(validW))))
        else $error("Mask register did not take the write.");

    a_mode3_mask_read: assert property (
        (ce && hostRdEn && selMaskW && (inputMode == MODE_MIXED)) |=> (hostRdData[6] == 1'b0))
        else $error("Reserved mask bit read as one in mode 3.");

    a_mode1_ch7_low: assert property (
        (ce && evtValid && (inputMode == MODE_SINGLE_ALL) && (evtChannel == TEMP_BIT)
         && evtBelowLow && !chanDisable[TEMP_BIT]) |=> bankBus.statusQ[TEMP_BIT])
        else $error("Input 7 low-limit event lost in mode 1.");

    a_pin_disabled: assert property (
        (ce && !alarmPinEnable) |=> alarmOut_n)
        else $error("Alarm pin driven while disabled.");

    a_clear_releases: assert property (
        (ce && alarmClear) |=> (alarmOut_n && monitorHalt))
        else $error("Alarm clear did not release pin and halt loop.");

    a_disabled_silent: assert property (
        (evtValid && chanDisable[evtChannel]) |-> (setVecW == STATUS_RESET))
        else $error("Disabled channel raised a flag.");

    function automatic logic maskQBit();
        return |(setVecW & bankBus.maskQ);
    endfunction

    a_pin_follows_flag: assert property (
        (ce && (setVecW != STATUS_RESET) && !maskQBit() && alarmPinEnable && !alarmClear)
        ##1 (ce && alarmPinEnable && !alarmClear) |=> !alarmOut_n)
        else $error("Alarm pin not driven for an unmasked flag.");

    a_pin_follows_pending: assert property (
        (ce && (pendingW != STATUS_RESET) && alarmPinEnable && !alarmClear) |=> !alarmOut_n)
        else $error("Alarm pin released with an unmasked flag pending.");

    // Sticky and hold checks catch a flag dropped without a clear and a mask change without a write.
    a_flag_stays_set: assert property (
        (ce && !statusClr) |=> ((bankBus.statusQ & $past(bankBus.statusQ)) == $past(bankBus.statusQ)))
        else $error("Flag dropped without a clear.");

    a_mask_holds_idle: assert property (
        (ce && !(hostWrEn && selMaskW)) |=> (bankBus.maskQ == $past(bankBus.maskQ)))
        else $error("Mask register changed without a write.");

    a_temp_high_sets: assert property (
        (ce && evtValid && (inputMode != MODE_SINGLE_ALL) && (evtChannel == TEMP_BIT)
         && evtAboveHigh && !chanDisable[TEMP_BIT]) |=> bankBus.statusQ[TEMP_BIT])
        else $error("Temperature flag missed a high-limit event.");

    a_flag_read_back: assert property (
        (ce && hostRdEn && selStatusW) |=> (hostRdData == ($past(bankBus.statusQ) & $past(validW))))
        else $error("Flag read did not return the stored flags.");

    a_halt_follows_clear: assert property (
        (ce && !alarmClear) |=> !monitorHalt)
        else $error("Monitoring loop halted without a clear.");

    a_mode2_mask_pairs: assert property (
        (ce && hostWrEn && selMaskW && (inputMode == MODE_PSEUDO_DIFF))
        |=> ((bankBus.maskQ & ~VALID_MODE2) == MASK_RESET))
        else $error("Reserved mask bit stored in mode 2.");

    a_mode3_mask_pairs: assert property (
        (ce && hostWrEn && selMaskW && (inputMode == MODE_MIXED))
        |=> ((bankBus.maskQ & ~VALID_MODE3) == MASK_RESET))
        else $error("Reserved mask bit stored in mode 3.");

    c_alarm_raised:  cover property (ce && $fell(alarmOut_n));
    c_masked_event:  cover property (ce && |(setVecW & bankBus.maskQ));
    c_clear_release: cover property (!alarmOut_n ##1 (ce && alarmClear) ##1 alarmOut_n);
    c_pair_mode2:    cover property (ce && (inputMode == MODE_PSEUDO_DIFF) && setVecW[3]);
    c_flags_frozen:  cover property (!ce && evtValid);

endmodule // lasm_alarm_top

/* sim/lasm_host_model.sv */
// Host-side model of the register port, standing in for the serial bus engine.
// Assumes the block samples strobes on rising core_clk; requests change only after an edge.
`timescale 1ns/1ns
module lasm_host_model
    import lasm_pkg::*;
(
    // Clock
    input  wire logic                  core_clk,
    // Register port toward the block
    output logic                       hostWrEn,
    output logic                       hostRdEn,
    output logic [ADDR_WIDTH-1:0]      hostAddr,
    output logic [7:0]                 hostWrData,
    input  wire logic [7:0]            hostRdData
);
    initial begin
        hostWrEn = 1'b0;
        hostRdEn = 1'b0;
        hostAddr = '1;
        hostWrData = 8'h00;
    end
    task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        hostWrEn <= 1'b1;
        hostAddr <= a;
        hostWrData <= d;
        @(posedge core_clk);
        hostWrEn <= 1'b0;
        // Data no longer held after the strobe, so show its inverse.
        hostWrData <= ~d;
    endtask
    task automatic rd(input logic [ADDR_WIDTH-1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        hostRdEn <= 1'b1;
        hostAddr <= a;
        @(posedge core_clk);
        hostRdEn <= 1'b0;
        #1;
        d = hostRdData;
    endtask
endmodule // lasm_host_model

/* sim/lasm_alarm_top_bench.sv */
// Self-checking bench of the limit alarm block: events in all modes, mask in modes 1 to 3, pin in modes 1 and 2.
// Assumes the host model drives the register port; every input changes at a rising edge.
`timescale 1ns/1ns
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin failCount++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module lasm_alarm_top_bench
    import lasm_pkg::*;
;
    logic                  core_clk = 1'b0;
    logic                  reset_n = 1'b0;
    logic [1:0]            inputMode = 2'h0;
    logic                  alarmPinEnable = 1'b1, alarmClear = 1'b0, statusClr = 1'b0, ce = 1'b1;
    logic                  evtValid = 1'b0, evtAboveHigh = 1'b0, evtBelowLow = 1'b0;
    logic [2:0]            evtChannel = 3'h0;
    logic [7:0]            chanDisable = 8'h00, hostRdData, hostWrData, rdVal;
    logic                  hostWrEn, hostRdEn, alarmOut_n, monitorHalt;
    logic [ADDR_WIDTH-1:0] hostAddr;
    int                    failCount = 0, nChecks = 0;

    initial begin
        forever #20 core_clk = ~core_clk;
    end
    lasm_alarm_top u_lasm_alarm_top (.core_clk, .reset_n, .ce, .hostWrEn, .hostRdEn, .hostAddr,
        .hostWrData, .hostRdData, .inputMode, .alarmPinEnable, .alarmClear, .chanDisable, .statusClr,
        .evtValid, .evtChannel, .evtAboveHigh, .evtBelowLow, .alarmOut_n, .monitorHalt);
    lasm_host_model u_lasm_host_model (.core_clk, .hostWrEn, .hostRdEn, .hostAddr, .hostWrData, .hostRdData);

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic evt(input logic [2:0] ch, input logic hi, input logic lo);
        @(posedge core_clk);
        evtValid <= 1'b1;
        evtChannel <= ch;
        evtAboveHigh <= hi;
        evtBelowLow <= lo;
        @(posedge core_clk);
        evtValid <= 1'b0;
    endtask
    task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
        u_lasm_host_model.rd(a, rdVal);
        `CHK(rdVal, e)
    endtask
    task automatic pin_is(input logic e);
        tick(2);
        `CHK(alarmOut_n, e)
    endtask
    task automatic setup(input logic [1:0] m);
        @(posedge core_clk);
        statusClr <= 1'b1;
        inputMode <= m;
        @(posedge core_clk);
        statusClr <= 1'b0;
        u_lasm_host_model.wr(8'h03, 8'h00);
    endtask

    task automatic t_reset();
        #1;
        `CHK(alarmOut_n, 1'b1)
        `CHK(monitorHalt, 1'b0)
        `CHK(hostRdData, 8'h00)
        reg_is(8'h01, 8'h00);
        reg_is(8'h03, 8'h00);
        reg_is(8'h02, 8'h00);
    endtask
    task automatic t_mode1();
        setup(2'h1);
        evt(3'h2, 1'b0, 1'b1);
        pin_is(1'b0);
        u_lasm_host_model.wr(8'h01, 8'h00);
        reg_is(8'h01, 8'h04);
        evt(3'h7, 1'b1, 1'b0);
        reg_is(8'h01, 8'h84);
        u_lasm_host_model.wr(8'h03, 8'h84);
        pin_is(1'b1);
        reg_is(8'h01, 8'h84);
        reg_is(8'h03, 8'h84);
    endtask
    task automatic t_mode0();
        setup(2'h0);
        evt(3'h7, 1'b0, 1'b1);
        reg_is(8'h01, 8'h00);
        evt(3'h7, 1'b1, 1'b0);
        evt(3'h6, 1'b1, 1'b0);
        reg_is(8'h01, 8'hC0);
    endtask
    task automatic t_mode2();
        setup(2'h2);
        evt(3'h5, 1'b1, 1'b0);
        reg_is(8'h01, 8'h00);
        evt(3'h3, 1'b1, 1'b0);
        evt(3'h1, 1'b0, 1'b1);
        reg_is(8'h01, 8'h0A);
        u_lasm_host_model.wr(8'h03, 8'hFF);
        reg_is(8'h03, 8'h8F);
        pin_is(1'b1);
    endtask
    task automatic t_mode3();
        setup(2'h3);
        evt(3'h6, 1'b1, 1'b0);
        reg_is(8'h01, 8'h00);
        evt(3'h5, 1'b0, 1'b1);
        evt(3'h4, 1'b1, 1'b0);
        reg_is(8'h01, 8'h30);
        u_lasm_host_model.wr(8'h03, 8'hFF);
        reg_is(8'h03, 8'hBF);
    endtask
    task automatic t_pin();
        setup(2'h1);
        evt(3'h0, 1'b1, 1'b0);
        pin_is(1'b0);
        @(posedge core_clk);
        alarmPinEnable <= 1'b0;
        pin_is(1'b1);
        @(posedge core_clk);
        alarmPinEnable <= 1'b1;
        pin_is(1'b0);
        @(posedge core_clk);
        alarmClear <= 1'b1;
        pin_is(1'b1);
        `CHK(monitorHalt, 1'b1)
        reg_is(8'h01, 8'h01);
        @(posedge core_clk);
        alarmClear <= 1'b0;
        pin_is(1'b0);
        `CHK(monitorHalt, 1'b0)
    endtask
    task automatic t_disable();
        setup(2'h1);
        chanDisable <= 8'h08;
        evt(3'h3, 1'b1, 1'b0);
        evt(3'h2, 1'b1, 1'b0);
        reg_is(8'h01, 8'h04);
        @(posedge core_clk);
        chanDisable <= 8'h00;
    endtask
    // A frozen block drops the event and ignores the clear until it runs again.
    task automatic t_freeze();
        @(posedge core_clk);
        ce <= 1'b0;
        alarmClear <= 1'b1;
        evt(3'h1, 1'b1, 1'b0);
        pin_is(1'b0);
        `CHK(monitorHalt, 1'b0)
        @(posedge core_clk);
        ce <= 1'b1;
        alarmClear <= 1'b0;
        reg_is(8'h01, 8'h04);
    endtask
    task automatic t_clr_race();
        @(posedge core_clk);
        statusClr <= 1'b1;
        evtValid <= 1'b1;
        evtChannel <= 3'h5;
        evtAboveHigh <= 1'b1;
        @(posedge core_clk);
        statusClr <= 1'b0;
        evtValid <= 1'b0;
        reg_is(8'h01, 8'h20);
    endtask
    task automatic t_midreset();
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
        t_mode1();
        t_mode0();
        t_mode2();
        t_mode3();
        t_pin();
        t_disable();
        t_freeze();
        t_clr_race();
        t_midreset();
        print_verdict();
    end
    // A hang anywhere above ends here as a counted mismatch.
    initial begin
        repeat (20000) @(posedge core_clk);
        failCount++;
        print_verdict();
    end
endmodule // lasm_alarm_top_bench
